// File: hdl/scs_pkg.sv
// Constants shared by both ends of the status and control semaphore.
package scs_pkg;
  localparam int unsigned DATA_W       = 16;
  localparam int unsigned WORD_W       = 32;
  localparam int unsigned FRAME_WORDS  = 14;
  localparam int unsigned FRAME_BITS   = FRAME_WORDS * WORD_W;
  localparam int unsigned CELL_BITS    = 396;
  localparam int unsigned PAD_BITS     = 20;
  localparam int unsigned IDX_W        = 4;
  localparam int unsigned FAR_W        = 8;
  localparam logic [3:0]  WR_LOC       = 4'hf;
  localparam logic [3:0]  RD_LOC       = 4'he;
  localparam int unsigned TOP_BIT_IDX  = 92;
  localparam int unsigned BIT_PITCH    = 18;
  localparam int unsigned CTRL_SHIFT   = 1;
  localparam logic [7:0]  MAJOR_ADDR   = 8'h16;
  localparam logic [7:0]  MINOR_ADDR   = 8'h2f;
  localparam logic [3:0]  LAST_WORD    = 4'hd;

  // Frame bit that holds the status copy of word bit k.
  function automatic int unsigned stat_idx(input int unsigned k);
    return TOP_BIT_IDX + BIT_PITCH * (DATA_W - 1 - k);
  endfunction

  // Frame bit that holds the control copy of word bit k.
  function automatic int unsigned ctrl_idx(input int unsigned k);
    return stat_idx(k) + CTRL_SHIFT;
  endfunction
endpackage

// File: hdl/scs_cfg_if.sv
// Configuration port between the host end and the semaphore column.
`timescale 1ns/1ps
`default_nettype none
interface scs_cfg_if;
  logic [7:0]  far_major;
  logic [7:0]  far_minor;
  logic        wr_valid;
  logic        rd_req;
  logic [3:0]  word_idx;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        rvalid;

  modport dev
  (
    input  far_major,
    input  far_minor,
    input  wr_valid,
    input  rd_req,
    input  word_idx,
    input  wdata,
    output rdata,
    output rvalid
  );

  modport host
  (
    output far_major,
    output far_minor,
    output wr_valid,
    output rd_req,
    output word_idx,
    output wdata,
    input  rdata,
    input  rvalid
  );
endinterface
`default_nettype wire

// File: hdl/scs_dev_end.sv
// Semaphore column: sixteen dual-port one-bit cells reached by user logic and the configuration port.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Sixteen dual-port cells hold one 16-bit word.
// - User writes always land at location 1111.
// - Read word always shows location 1110.
// - Each cell is two one-bit stores.
// - Host rewrites one frame, changing needed bits.
// - Host reads frame back, extracts status bits.
// - Updated flag sets on host write, clears on consume.
// - No other LUT memory in this column.
// - Frame is fourteen 32-bit words with padding.
// - Host addresses major 22, minor 47.
// - Bit 15 sits in the topmost cell.
// - Configuration memory holds cell bits inverted.
// - Top bit at index 92, pitch 18.
module scs_dev_end
(
  input  wire logic                       ref_clk,
  input  wire logic                       rst_b,
  input  wire logic                       we,
  input  wire logic [scs_pkg::DATA_W-1:0] data,
  output logic      [scs_pkg::DATA_W-1:0] rout,
  output logic                            host_updated,
  input  wire logic                       updated_ack,
  scs_cfg_if.dev                          cfg
);
  logic [scs_pkg::DATA_W-1:0]     stat_bit;
  logic [scs_pkg::FRAME_BITS-1:0] frame_img;
  logic [31:0]                    rdata;
  logic                           rvalid;
  wire                            major_hit;
  wire                            minor_hit;
  wire                            frame_hit;
  wire                            frame_wr;
  wire                            frame_rd;
  wire                            idx_ok;
  wire                            last_word;
  wire                            frame_end;
  wire  [31:0]                    word_slice;
  wire  [31:0]                    word_sel;
  wire  [31:0]                    next_rdata;
  wire                            next_rvalid;
  wire                            flag_set;
  wire                            flag_clr;
  wire                            next_host_updated;

  // Refuse package values that the frame layout and the port widths below cannot serve.
  if (scs_pkg::DATA_W == 0)
  begin : g_chk_width
    $error("The semaphore word needs at least one bit.");
  end

  if (scs_pkg::WORD_W != 32 || scs_pkg::FAR_W != 8 || scs_pkg::IDX_W != 4)
  begin : g_chk_port
    $error("Package widths differ from the configuration port widths.");
  end

  if (scs_pkg::FRAME_BITS != scs_pkg::CELL_BITS + scs_pkg::PAD_BITS + scs_pkg::WORD_W)
  begin : g_chk_frame
    $error("Frame size does not equal cells, padding and dummy word.");
  end

  if (scs_pkg::FRAME_BITS != scs_pkg::FRAME_WORDS * scs_pkg::WORD_W)
  begin : g_chk_whole
    $error("Frame size is not a whole number of port words.");
  end

  if (scs_pkg::FRAME_WORDS > (1 << scs_pkg::IDX_W))
  begin : g_chk_words
    $error("Frame has more words than the word index can reach.");
  end

  if (scs_pkg::LAST_WORD != scs_pkg::FRAME_WORDS - 1)
  begin : g_chk_last
    $error("Last word index does not close the frame.");
  end

  if (scs_pkg::PAD_BITS + (scs_pkg::CELL_BITS % scs_pkg::WORD_W) != scs_pkg::WORD_W)
  begin : g_chk_pad
    $error("Padding does not close the last word of cell bits.");
  end

  if (scs_pkg::WR_LOC == scs_pkg::RD_LOC)
  begin : g_chk_loc
    $error("Write and read locations must differ.");
  end

  if (scs_pkg::CTRL_SHIFT == 0 || scs_pkg::CTRL_SHIFT >= scs_pkg::BIT_PITCH)
  begin : g_chk_shift
    $error("Control copy would collide with a status copy.");
  end

  if (scs_pkg::TOP_BIT_IDX >= scs_pkg::CELL_BITS)
  begin : g_chk_top
    $error("Top word bit falls outside the memory cell bits.");
  end

  if (scs_pkg::ctrl_idx(0) >= scs_pkg::CELL_BITS)
  begin : g_chk_cells
    $error("Lowest word bit falls outside the memory cell bits.");
  end

  // The configuration port only touches this column when both parts of the frame address match.
  assign major_hit = (cfg.far_major == scs_pkg::MAJOR_ADDR);
  assign minor_hit = (cfg.far_minor == scs_pkg::MINOR_ADDR);
  assign frame_hit = major_hit && minor_hit;
  assign frame_wr  = cfg.wr_valid && frame_hit;
  assign frame_rd  = cfg.rd_req && frame_hit;
  assign idx_ok    = (cfg.word_idx <= scs_pkg::LAST_WORD);
  assign last_word = (cfg.word_idx == scs_pkg::LAST_WORD);
  assign frame_end = frame_wr && last_word;

  genvar k;
  generate
    for (k = 0; k < scs_pkg::DATA_W; k++)
    begin : g_cell
      localparam int unsigned SIDX = scs_pkg::stat_idx(k);
      localparam int unsigned CIDX = scs_pkg::ctrl_idx(k);
      localparam logic [3:0]  SWRD = 4'(SIDX / scs_pkg::WORD_W);
      localparam logic [3:0]  CWRD = 4'(CIDX / scs_pkg::WORD_W);
      localparam int unsigned SPOS = SIDX % scs_pkg::WORD_W;
      localparam int unsigned CPOS = CIDX % scs_pkg::WORD_W;

      // One dual_port_lut_cell. Only locations 1111 and 1110 are ever addressed, so only they are built.
      logic loc_wr;
      logic loc_rd;
      wire  host_stat   = frame_wr && (cfg.word_idx == SWRD);
      wire  host_ctrl   = frame_wr && (cfg.word_idx == CWRD);
      wire  host_sval   = ~cfg.wdata[SPOS];
      wire  host_cval   = ~cfg.wdata[CPOS];
      wire  host_wr_val = host_stat ? host_sval : loc_wr;
      // A user write beats a host write to the status location in the same cycle.
      wire  next_loc_wr = we ? data[k] : host_wr_val;
      wire  next_loc_rd = host_ctrl ? host_cval : loc_rd;

      always_ff @(posedge ref_clk or negedge rst_b)
      begin
        if (!rst_b)
          loc_wr <= 1'b0;
        else
          loc_wr <= next_loc_wr;
      end

      always_ff @(posedge ref_clk or negedge rst_b)
      begin
        if (!rst_b)
          loc_rd <= 1'b0;
        else
          loc_rd <= next_loc_rd;
      end

      assign stat_bit[k] = loc_wr;
      assign rout[k]     = loc_rd;
    end
  endgenerate

  // Readback image: cell bits inverted, everything else reads as one.
  always_comb
  begin
    frame_img = '1;
    for (int unsigned i = 0; i < scs_pkg::DATA_W; i++)
    begin
      frame_img[scs_pkg::stat_idx(i)] = ~stat_bit[i];
      frame_img[scs_pkg::ctrl_idx(i)] = ~rout[i];
    end
  end

  // Words past the end of the frame read as all ones instead of an out-of-range slice.
  assign word_slice  = frame_img[cfg.word_idx * scs_pkg::WORD_W +: scs_pkg::WORD_W];
  assign word_sel    = idx_ok ? word_slice : 32'hffff_ffff;
  assign next_rdata  = frame_rd ? word_sel : rdata;
  assign next_rvalid = frame_rd;

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      rvalid <= 1'b0;
    else
      rvalid <= next_rvalid;
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      rdata <= 32'h0000_0000;
    else
      rdata <= next_rdata;
  end

  assign cfg.rdata  = rdata;
  assign cfg.rvalid = rvalid;

  // The set wins over an acknowledge in the same cycle, so a fresh frame write is never lost.
  assign flag_set          = frame_end;
  assign flag_clr          = updated_ack;
  assign next_host_updated = flag_set || (host_updated && !flag_clr);

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      host_updated <= 1'b0;
    else
      host_updated <= next_host_updated;
  end
endmodule
`default_nettype wire

// File: hdl/scs_host_end.sv
// Host end: walks the frame by read-modify-write to deliver control and collect status.
`timescale 1ns/1ps
`default_nettype none
module scs_host_end
(
  input  wire logic                       ref_clk,
  input  wire logic                       rst_b,
  input  wire logic                       write_req,
  input  wire logic                       read_req,
  input  wire logic [scs_pkg::DATA_W-1:0] ctrl_word,
  output logic      [scs_pkg::DATA_W-1:0] status_word,
  output logic                            busy,
  output logic                            done,
  scs_cfg_if.host                         cfg
);
  typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WAIT, ST_WRITE} scs_host_st_t;

  scs_host_st_t               st;
  logic                       do_write;
  logic [3:0]                 widx;
  logic [scs_pkg::DATA_W-1:0] ctrl;
  logic [31:0]                wword;
  logic                       wr_valid;
  logic                       rd_req;
  logic [31:0]                next_word;
  logic [scs_pkg::DATA_W-1:0] next_status;

  // Replace only the control bits of this word; keep every other bit as read.
  always_comb
  begin
    next_word   = cfg.rdata;
    next_status = status_word;
    for (int unsigned i = 0; i < scs_pkg::DATA_W; i++)
    begin
      if (4'(scs_pkg::ctrl_idx(i) / scs_pkg::WORD_W) == widx)
        next_word[scs_pkg::ctrl_idx(i) % scs_pkg::WORD_W] = ~ctrl[i];
      if (4'(scs_pkg::stat_idx(i) / scs_pkg::WORD_W) == widx)
        next_status[i] = ~cfg.rdata[scs_pkg::stat_idx(i) % scs_pkg::WORD_W];
    end
  end

  wire last = (widx == scs_pkg::LAST_WORD);

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st          <= ST_IDLE;
      do_write    <= 1'b0;
      widx        <= 4'h0;
      ctrl        <= 16'h0000;
      wword       <= 32'h0000_0000;
      wr_valid    <= 1'b0;
      rd_req      <= 1'b0;
      status_word <= 16'h0000;
      busy        <= 1'b0;
      done        <= 1'b0;
    end
    else
    begin
      wr_valid <= 1'b0;
      rd_req   <= 1'b0;
      done     <= 1'b0;
      case (st)
        ST_IDLE:
        begin
          if (write_req || read_req)
          begin
            do_write <= write_req;
            ctrl     <= ctrl_word;
            widx     <= 4'h0;
            busy     <= 1'b1;
            rd_req   <= 1'b1;
            st       <= ST_WAIT;
          end
        end
        ST_READ:
        begin
          rd_req <= 1'b1;
          st     <= ST_WAIT;
        end
        ST_WAIT:
        begin
          if (cfg.rvalid)
          begin
            status_word <= next_status;
            if (do_write)
            begin
              wword    <= next_word;
              wr_valid <= 1'b1;
              st       <= ST_WRITE;
            end
            else if (last)
            begin
              busy <= 1'b0;
              done <= 1'b1;
              st   <= ST_IDLE;
            end
            else
            begin
              widx <= widx + 4'h1;
              st   <= ST_READ;
            end
          end
        end
        ST_WRITE:
        begin
          if (last)
          begin
            busy <= 1'b0;
            done <= 1'b1;
            st   <= ST_IDLE;
          end
          else
          begin
            widx <= widx + 4'h1;
            st   <= ST_READ;
          end
        end
        default:
          st <= ST_IDLE;
      endcase
    end
  end

  assign cfg.far_major = scs_pkg::MAJOR_ADDR;
  assign cfg.far_minor = scs_pkg::MINOR_ADDR;
  assign cfg.wr_valid  = wr_valid;
  assign cfg.rd_req    = rd_req;
  assign cfg.word_idx  = widx;
  assign cfg.wdata     = wword;
endmodule
`default_nettype wire

// File: verif/scs_cfg_asserts.sv
// Checks on the configuration port between the two ends.
`timescale 1ns/1ps
`default_nettype none
module scs_cfg_asserts
(
  input wire logic        ref_clk,
  input wire logic        rst_b,
  input wire logic [7:0]  far_major,
  input wire logic [7:0]  far_minor,
  input wire logic        wr_valid,
  input wire logic        rd_req,
  input wire logic [3:0]  word_idx,
  input wire logic [31:0] wdata,
  input wire logic [31:0] rdata,
  input wire logic        rvalid
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  wire logic hit = far_major == 8'h16 && far_minor == 8'h2f;
  frame_addr_a: assert property ((rd_req || wr_valid) |-> hit)
    else $error("bad frame address");
  word_range_a: assert property ((rd_req || wr_valid) |-> word_idx <= 4'hd)
    else $error("word past frame end");
  read_answer_a: assert property (rd_req && hit |=> rvalid)
    else $error("read not answered");
  answer_cause_a: assert property (rvalid |-> $past(rd_req))
    else $error("stray rvalid");
  lead_ones_a: assert property (rvalid && $past(word_idx) < 4'h2 |-> rdata == 32'hffffffff)
    else $error("lead word not ones");
  pad_bits_a: assert property (rvalid && $past(word_idx) == 4'hc |-> rdata[31:12] == 20'hfffff)
    else $error("padding not ones");
  dummy_keep_a: assert property (wr_valid && word_idx == 4'hd |-> wdata == 32'hffffffff)
    else $error("dummy word changed");
  rmw_order_a: assert property (wr_valid |-> $past(rvalid) && $past(word_idx, 2) == word_idx)
    else $error("write without readback");
endmodule
`default_nettype wire

// File: verif/tb_top.sv
// Bench joining host end and device end over the configuration port.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        ref_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        we = 1'b0;
  logic        write_req = 1'b0;
  logic        read_req = 1'b0;
  logic        updated_ack = 1'b0;
  logic [15:0] data = 16'h0000;
  logic [15:0] ctrl_word = 16'h0000;
  logic [15:0] rout, rout_2, status_word, s, c, prev;
  logic        host_updated, updated_2, busy, done;
  logic [31:0] frm [14];
  logic [3:0]  last_idx = 4'h0;
  logic [15:0] corner [4] = '{16'h8000, 16'h0001, 16'hffff, 16'h0000};
  int          num_errors = 0;
  int          comparisons = 0;
  int          cycles = 0;
  scs_cfg_if cfg ();
  scs_cfg_if cfg_2 ();
  scs_dev_end i_scs_dev_end (.ref_clk(ref_clk), .rst_b(rst_b), .we(we), .data(data), .rout(rout),
    .host_updated(host_updated), .updated_ack(updated_ack), .cfg(cfg.dev));
  scs_host_end i_scs_host_end (.ref_clk(ref_clk), .rst_b(rst_b), .write_req(write_req), .read_req(read_req),
    .ctrl_word(ctrl_word), .status_word(status_word), .busy(busy), .done(done), .cfg(cfg.host));
  scs_dev_end i_scs_dev_end_2 (.ref_clk(ref_clk), .rst_b(rst_b), .we(1'b0), .data(16'h0000), .rout(rout_2),
    .host_updated(updated_2), .updated_ack(1'b0), .cfg(cfg_2.dev));
  scs_cfg_asserts i_scs_cfg_asserts (.ref_clk(ref_clk), .rst_b(rst_b), .far_major(cfg.far_major),
    .far_minor(cfg.far_minor), .wr_valid(cfg.wr_valid), .rd_req(cfg.rd_req), .word_idx(cfg.word_idx),
    .wdata(cfg.wdata), .rdata(cfg.rdata), .rvalid(cfg.rvalid));
  always #4 ref_clk = ~ref_clk;
  // Captures the frame image as it crosses the port.
  always @(posedge ref_clk)
  begin
    if (cfg.rvalid) frm[last_idx] <= cfg.rdata;
    last_idx <= cfg.word_idx;
    cycles++;
    if (cycles == 5000)
    begin
      num_errors++;
      end_sim();
    end
  end
  function automatic logic [15:0] frame_status();
    logic [15:0] r;
    int          i;
    for (int k = 0; k < 16; k++)
    begin
      i = 92 + 18 * (15 - k);
      r[k] = ~frm[i / 32][i % 32];
    end
    return r;
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: %s got %h", $time, msg, got);
    end
  endtask
  task automatic host_op(input logic wr, input logic [15:0] cw);
    int n;
    n = 0;
    write_req <= wr;
    read_req <= !wr;
    ctrl_word <= cw;
    @(posedge ref_clk);
    write_req <= 1'b0;
    read_req <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk({15'h0, busy}, 16'h0001, "busy");
    while (done !== 1'b1 && n < 100)
    begin
      @(posedge ref_clk);
      n++;
    end
    if (n == 100) num_errors++;
  endtask
  task automatic side_write(input logic [7:0] major);
    cfg_2.far_major <= major;
    cfg_2.wr_valid <= 1'b1;
    @(posedge ref_clk);
    cfg_2.wr_valid <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask
  task automatic end_sim();
    $display("comparisons %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    cfg_2.far_major = 8'h16;
    cfg_2.far_minor = 8'h2f;
    cfg_2.wr_valid = 1'b0;
    cfg_2.rd_req = 1'b0;
    cfg_2.word_idx = 4'hd;
    cfg_2.wdata = 32'h0;
    prev = 16'h0000;
    void'($urandom(32'h360c5784));
    repeat (5) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    for (int t = 0; t < 8; t++)
    begin
      s = (t < 4) ? corner[t] : 16'($urandom);
      c = (t < 4) ? ~corner[t] : 16'($urandom);
      we <= 1'b1;
      data <= s;
      @(posedge ref_clk);
      we <= 1'b0;
      host_op(1'b0, 16'h0000);
      chk(status_word, s, "status");
      chk(frame_status(), s, "frame");
      chk(rout, prev, "held");
      host_op(1'b1, c);
      chk(rout, c, "control");
      chk(status_word, s, "kept");
      chk({15'h0, host_updated}, 16'h0001, "flag");
      updated_ack <= 1'b1;
      @(posedge ref_clk);
      updated_ack <= 1'b0;
      repeat (2) @(posedge ref_clk);
      chk({15'h0, host_updated}, 16'h0000, "ack");
      prev = c;
    end
    side_write(8'h15);
    chk({15'h0, updated_2}, 16'h0000, "refused");
    side_write(8'h16);
    chk({15'h0, updated_2}, 16'h0001, "taken");
    chk(rout_2, 16'h0000, "dummy");
    end_sim();
  end
endmodule
`default_nettype wire
